// ---- fan_pkg.sv ----
// Shared constants and types for the fan PWM supervisor
package fan_pkg;
    // PWM period: nominal 30 Hz, 26 to 34 Hz
    localparam int PWM_FREQ_HZ = 30;
    localparam int CLK_FREQ_HZ = 250000000;
    localparam int PWM_PERIOD_CYCLES = CLK_FREQ_HZ / PWM_FREQ_HZ;
    // Duty resolution of the digitized control level
    localparam int DUTY_BITS = 8;
    localparam logic [7:0] DUTY_FULL = 8'hff;
    // Counts in PWM periods
    localparam logic [5:0] STARTUP_PERIODS = 6'h20;
    localparam logic [5:0] MISSING_PERIODS = 6'h20;
    localparam logic [5:0] DIAG_PERIODS = 6'h03;
    // Control span printed as millivolts; comparators live outside
    localparam int SPAN_LOW_MV = 1250;
    localparam int SPAN_HIGH_MV = 2650;
    localparam int AS_HYST_MV = 70;
    localparam logic [5:0] PERIOD_RESET = 6'h00;

    typedef enum logic [2:0] {
        ST_SHUTDOWN,
        ST_AUTO_OFF,
        ST_STARTUP,
        ST_RETRY,
        ST_RUN,
        ST_DIAG,
        ST_RESTART,
        ST_FAULT
    } mode_e;
endpackage : fan_pkg

// ---- pwm_tick.sv ----
// Free-running PWM period counter with wrap pulse
`timescale 1ns/10ps
module pwm_tick #(
    parameter int PERIOD = fan_pkg::PWM_PERIOD_CYCLES
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // Period wrap and phase
    output logic period_start,
    output logic [fan_pkg::DUTY_BITS-1:0] phase
);
    typedef struct packed {
        logic [31:0] count;
    } tick_s;

    tick_s state;
    tick_s next_state;

    always_comb begin
        next_state = state;
        if (state.count >= 32'(PERIOD - 1)) begin
            next_state.count = 32'h0;
        end else begin
            next_state.count = state.count + 32'h1;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    assign period_start = (state.count == 32'h0);
    // Phase scales count into duty units; 64-bit product avoids overflow
    assign phase = fan_pkg::DUTY_BITS'((64'(state.count) * 64'h100) / 64'(PERIOD));
endmodule : pwm_tick

// ---- pulse_seen.sv ----
// Fan pulse edge latch, cleared at each PWM period start
`timescale 1ns/10ps
module pulse_seen (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // Control
    input wire logic period_start,
    input wire logic clear,
    input wire logic fan_pulse,
    // Result for the period just ended
    output logic seen
);
    typedef struct packed {
        logic prev;
        logic acc;
        logic seen;
    } ps_s;

    ps_s state;
    ps_s next_state;

    always_comb begin
        next_state = state;
        next_state.prev = fan_pulse;
        if (clear) begin
            // An edge in the clearing cycle is kept, so the set wins over the clear
            next_state.acc = fan_pulse & ~state.prev;
            next_state.seen = 1'b0;
        end else if (period_start) begin
            // An edge in the wrap cycle counts toward the period that closes
            next_state.seen = state.acc | (fan_pulse & ~state.prev);
            next_state.acc = 1'b0;
        end else if (fan_pulse & ~state.prev) begin
            next_state.acc = 1'b1;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    assign seen = state.seen;
endmodule : pulse_seen

// ---- fan_pwm_fault_supervisor.sv ----
// Top of the fan PWM controller with start-up and fault supervision
`timescale 1ns/10ps
module fan_pwm_fault_supervisor #(
    parameter int PWM_PERIOD = fan_pkg::PWM_PERIOD_CYCLES
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst_b,
    // Digitized control level, 0 at span low, full at span high
    input wire logic [fan_pkg::DUTY_BITS-1:0] control_level,
    // Comparator outcomes, synchronous to sys_clk
    input wire logic below_shutdown_threshold,
    input wire logic above_release_threshold,
    input wire logic below_autoshutdown_threshold_input,
    input wire logic above_autoshutdown_hyst,
    input wire logic above_overtemp_threshold,
    // Commutation pulses from the sense path
    input wire logic fan_pulse,
    // Fan drive, active high
    output logic fan_drive,
    // Open-collector fault pin: low output enable pulls it low
    output logic fault_out,
    output logic fault_oe_b
);
    ////////////////////////////////////////////////////////////////////////
    // Reset release
    logic [1:0] rst_sync;
    logic rst_n;

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            rst_sync <= 2'b00;
        end else begin
            rst_sync <= {rst_sync[0], 1'b1};
        end
    end
    assign rst_n = rst_sync[1];

    ////////////////////////////////////////////////////////////////////////
    // Time base and pulse detection
    logic period_start;
    logic [fan_pkg::DUTY_BITS-1:0] phase;
    logic seen;
    logic clear_pulse;

    pwm_tick #(
        .PERIOD(PWM_PERIOD)
    ) u_tick (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .period_start(period_start),
        .phase(phase)
    );

    pulse_seen u_seen (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .period_start(period_start),
        .clear(clear_pulse),
        .fan_pulse(fan_pulse),
        .seen(seen)
    );

    ////////////////////////////////////////////////////////////////////////
    // Supervisor state
    typedef struct packed {
        fan_pkg::mode_e mode;
        logic [5:0] periods;
        logic [fan_pkg::DUTY_BITS-1:0] duty;
        logic drive;
        logic fault_low;
        logic first_period;
    } sup_s;

    sup_s state;
    sup_s next_state;
    logic full_duty;
    logic pwm_on;

    // Duty is latched at period start so each period has one width
    assign full_duty = (state.duty == fan_pkg::DUTY_FULL);
    assign pwm_on = full_duty | (phase < state.duty);

    // The seen flag lags one period; skip the first period of a timer
    function automatic logic pulse_ok(input logic s, input logic first);
        return s & ~first;
    endfunction : pulse_ok

    always_comb begin
        next_state = state;
        next_state.first_period = state.first_period & ~period_start;
        clear_pulse = 1'b0;
        if (period_start) begin
            next_state.duty = control_level;
        end
        case (state.mode)
            fan_pkg::ST_SHUTDOWN: begin
                next_state.periods = fan_pkg::PERIOD_RESET;
                if (above_release_threshold && !below_shutdown_threshold) begin
                    if (above_autoshutdown_hyst) begin
                        next_state.mode = fan_pkg::ST_STARTUP;
                        next_state.first_period = 1'b1;
                        clear_pulse = 1'b1;
                    end else begin
                        next_state.mode = fan_pkg::ST_AUTO_OFF;
                    end
                end
            end
            fan_pkg::ST_AUTO_OFF: begin
                next_state.periods = fan_pkg::PERIOD_RESET;
                if (above_autoshutdown_hyst && !below_autoshutdown_threshold_input) begin
                    next_state.mode = fan_pkg::ST_STARTUP;
                    next_state.first_period = 1'b1;
                    clear_pulse = 1'b1;
                end
            end
            fan_pkg::ST_STARTUP, fan_pkg::ST_RETRY, fan_pkg::ST_RESTART: begin
                if (period_start && pulse_ok(seen, state.first_period)) begin
                    next_state.mode = fan_pkg::ST_RUN;
                    next_state.periods = fan_pkg::PERIOD_RESET;
                end else if (period_start) begin
                    next_state.periods = state.periods + 6'h01;
                    if (state.periods + 6'h01 >= fan_pkg::STARTUP_PERIODS) begin
                        next_state.periods = fan_pkg::PERIOD_RESET;
                        next_state.first_period = 1'b1;
                        if (state.mode == fan_pkg::ST_STARTUP) begin
                            next_state.mode = fan_pkg::ST_RETRY;
                        end else begin
                            next_state.mode = fan_pkg::ST_FAULT;
                        end
                    end
                end
            end
            fan_pkg::ST_RUN: begin
                if (period_start && seen) begin
                    next_state.periods = fan_pkg::PERIOD_RESET;
                end else if (period_start) begin
                    next_state.periods = state.periods + 6'h01;
                    if (state.periods + 6'h01 >= fan_pkg::MISSING_PERIODS) begin
                        next_state.mode = fan_pkg::ST_DIAG;
                        next_state.periods = fan_pkg::PERIOD_RESET;
                        next_state.first_period = 1'b1;
                    end
                end
            end
            fan_pkg::ST_DIAG: begin
                if (period_start && pulse_ok(seen, state.first_period)) begin
                    next_state.mode = fan_pkg::ST_RUN;
                    next_state.periods = fan_pkg::PERIOD_RESET;
                end else if (period_start) begin
                    next_state.periods = state.periods + 6'h01;
                    if (state.periods + 6'h01 >= fan_pkg::DIAG_PERIODS) begin
                        next_state.mode = fan_pkg::ST_RESTART;
                        next_state.periods = fan_pkg::PERIOD_RESET;
                        next_state.first_period = 1'b1;
                    end
                end
            end
            fan_pkg::ST_FAULT: begin
                next_state.periods = fan_pkg::PERIOD_RESET;
            end
            default: begin
                next_state.mode = fan_pkg::ST_SHUTDOWN;
            end
        endcase
        // Shutdown has top priority and clears a latched fault
        if (below_shutdown_threshold) begin
            next_state.mode = fan_pkg::ST_SHUTDOWN;
            next_state.periods = fan_pkg::PERIOD_RESET;
        end else if (below_autoshutdown_threshold_input
                     && state.mode != fan_pkg::ST_FAULT
                     && state.mode != fan_pkg::ST_SHUTDOWN) begin
            next_state.mode = fan_pkg::ST_AUTO_OFF;
            next_state.periods = fan_pkg::PERIOD_RESET;
        end
        // Drive and fault levels registered from the next mode
        case (next_state.mode)
            fan_pkg::ST_STARTUP, fan_pkg::ST_RETRY, fan_pkg::ST_RESTART,
            fan_pkg::ST_DIAG: begin
                next_state.drive = 1'b1;
            end
            fan_pkg::ST_RUN: begin
                next_state.drive = pwm_on;
            end
            default: begin
                next_state.drive = 1'b0;
            end
        endcase
        case (next_state.mode)
            fan_pkg::ST_SHUTDOWN, fan_pkg::ST_AUTO_OFF: begin
                next_state.fault_low = 1'b0;
            end
            fan_pkg::ST_FAULT: begin
                next_state.fault_low = 1'b1;
            end
            default: begin
                // Warning follows full duty both ways, no latch
                next_state.fault_low = full_duty & above_overtemp_threshold;
            end
        endcase
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            // Power-up behaves as leaving shutdown
            state.mode <= fan_pkg::ST_SHUTDOWN;
            state.periods <= fan_pkg::PERIOD_RESET;
            state.duty <= '0;
            state.drive <= 1'b0;
            state.fault_low <= 1'b0;
            state.first_period <= 1'b1;
        end else begin
            state <= next_state;
        end
    end

    assign fan_drive = state.drive;
    assign fault_out = 1'b0;
    assign fault_oe_b = ~state.fault_low;

    ////////////////////////////////////////////////////////////////////////
    // Checks
    shdn_fault_high_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        state.mode == fan_pkg::ST_SHUTDOWN |-> fault_oe_b)
        else $error("fault pulled low in shutdown");
    auto_fault_high_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        state.mode == fan_pkg::ST_AUTO_OFF |-> fault_oe_b && !fan_drive)
        else $error("fault or drive active in auto-off");
    shdn_entry_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        below_shutdown_threshold |=> state.mode == fan_pkg::ST_SHUTDOWN)
        else $error("shutdown not entered");
    shdn_hold_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        state.mode == fan_pkg::ST_SHUTDOWN && !above_release_threshold
        |=> state.mode == fan_pkg::ST_SHUTDOWN)
        else $error("left shutdown below release");
    fault_latch_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        state.mode == fan_pkg::ST_FAULT && !below_shutdown_threshold
        |=> state.mode == fan_pkg::ST_FAULT && !fault_oe_b && !fan_drive)
        else $error("fan fault latch lost");
    start_drive_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        state.mode == fan_pkg::ST_STARTUP |-> fan_drive)
        else $error("drive off during start-up");
    overtemp_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        state.mode == fan_pkg::ST_RUN && full_duty && above_overtemp_threshold
        && !below_autoshutdown_threshold_input && !below_shutdown_threshold
        && !(period_start && control_level != fan_pkg::DUTY_FULL)
        ##1 state.mode == fan_pkg::ST_RUN |-> !fault_oe_b && fan_drive)
        else $error("overtemp warning missing");
    diag_count_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        state.mode == fan_pkg::ST_DIAG |-> state.periods < fan_pkg::DIAG_PERIODS)
        else $error("diagnostic overran");
    miss_count_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        state.mode == fan_pkg::ST_RUN |-> state.periods < fan_pkg::MISSING_PERIODS)
        else $error("missing pulse count overran");
    auto_entry_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        below_autoshutdown_threshold_input && !below_shutdown_threshold
        && state.mode != fan_pkg::ST_FAULT && state.mode != fan_pkg::ST_SHUTDOWN
        |=> state.mode == fan_pkg::ST_AUTO_OFF && !fan_drive)
        else $error("auto-shutdown not entered");
    auto_hold_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        state.mode == fan_pkg::ST_AUTO_OFF && !above_autoshutdown_hyst
        && !below_shutdown_threshold |=> state.mode == fan_pkg::ST_AUTO_OFF)
        else $error("left auto-off inside hysteresis");
    diag_drive_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        state.mode == fan_pkg::ST_DIAG |-> fan_drive)
        else $error("drive off during diagnostic");
    retry_drive_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        state.mode == fan_pkg::ST_RETRY || state.mode == fan_pkg::ST_RESTART
        |-> fan_drive)
        else $error("drive off during retry");
    warn_release_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        state.mode == fan_pkg::ST_RUN && !full_duty |=> fault_oe_b)
        else $error("overtemp warning held below full duty");
    fault_cause_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        !fault_oe_b && state.mode != fan_pkg::ST_FAULT
        |-> $past(full_duty && above_overtemp_threshold))
        else $error("fault pulled low with no cause");
    start_count_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        state.mode == fan_pkg::ST_STARTUP || state.mode == fan_pkg::ST_RETRY
        || state.mode == fan_pkg::ST_RESTART |-> state.periods < fan_pkg::STARTUP_PERIODS)
        else $error("start-up count overran");
endmodule : fan_pwm_fault_supervisor

// ---- fan_model.sv ----
// Behavioural brushless fan behind the low-side switch, with commutation pulses
`timescale 1ns/10ps
module fan_model #(
    parameter int SPIN_HOLD = 512,
    parameter int PULSE_GAP = 100
) (
    // Clock
    input wire logic sys_clk,
    // Switch drive and test control
    input wire logic fan_drive,
    input wire logic stall,
    // Commutation pulses
    output logic fan_pulse
);
    int spin = 0;
    int phase = 0;

    ////////////////////////////////////////////////////////////////////////////////
    // Rotor inertia carries it through PWM off time, but not forever
    always @(posedge sys_clk) begin
        if (fan_drive && !stall) begin
            spin <= SPIN_HOLD;
        end else if (spin > 0) begin
            spin <= spin - 1;
        end
        phase <= (phase + 1) % PULSE_GAP;
    end

    // A stalled or stopped rotor makes no current chops at all
    assign fan_pulse = (spin > 0) && !stall && (phase < 4);
endmodule : fan_model

// ---- tb_top.sv ----
// Self-checking testbench for the fan PWM supervisor
`timescale 1ns/10ps
module tb_top;
    localparam int PER = 256;
    localparam int LIMIT = 80000;
    logic sys_clk, rst_b, stall;
    logic [7:0] control_level;
    logic below_sd, above_rel, below_as, above_hyst, above_ot;
    logic fan_pulse, fan_drive, fault_out, fault_oe_b, fault_pin;
    int failures = 0;
    int n_tests = 0;
    int cyc = 0;

    // Pull-up on the open-collector fault pin
    assign fault_pin = fault_oe_b ? 1'b1 : fault_out;

    fan_pwm_fault_supervisor #(.PWM_PERIOD(PER)) DUT (
        .sys_clk(sys_clk), .rst_b(rst_b), .control_level(control_level),
        .below_shutdown_threshold(below_sd), .above_release_threshold(above_rel),
        .below_autoshutdown_threshold_input(below_as), .above_autoshutdown_hyst(above_hyst),
        .above_overtemp_threshold(above_ot), .fan_pulse(fan_pulse),
        .fan_drive(fan_drive), .fault_out(fault_out), .fault_oe_b(fault_oe_b));

    fan_model fan (.sys_clk(sys_clk), .fan_drive(fan_drive), .stall(stall),
        .fan_pulse(fan_pulse));

    ////////////////////////////////////////////////////////////////////////////////
    task automatic summarize();
        $display("comparisons %0d mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : summarize

    task automatic check_bit(input string name, input logic exp, input logic got);
        n_tests++;
        if (got !== exp) begin
            failures++;
            $display("FAIL %s expected %b seen %b", name, exp, got);
        end
    endtask : check_bit

    task automatic check_range(input string name, input int lo, input int hi, input int got);
        n_tests++;
        if (got < lo || got > hi) begin
            failures++;
            $display("FAIL %s expected %0d..%0d seen %0d", name, lo, hi, got);
        end
    endtask : check_range

    // Sampling at the falling edge keeps clear of the registered updates
    task automatic count_high(input int n, output int c);
        c = 0;
        repeat (n) begin
            @(negedge sys_clk);
            if (fan_drive === 1'b1) c++;
        end
    endtask : count_high

    task automatic wait_drive(input int lim, output int t);
        t = 0;
        do begin
            @(negedge sys_clk);
            t++;
        end while (fan_drive !== 1'b1 && t < lim);
    endtask : wait_drive

    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_powerup_stalled();
        int t, len;
        wait_drive(12, t);
        count_high(1, len);
        len = 0;
        while (fan_drive === 1'b1 && len < 80 * PER) begin
            @(negedge sys_clk);
            len++;
        end
        check_range("startup and retry hold", 63 * PER, 65 * PER, len);
        repeat (4) @(negedge sys_clk);
        check_bit("drive after failed start", 1'b0, fan_drive);
        check_bit("fault after failed start", 1'b0, fault_pin);
        @(posedge sys_clk) below_as <= 1'b1;
        count_high(2 * PER, len);
        check_range("latched drive", 0, 0, len);
        check_bit("latched fault", 1'b0, fault_pin);
    endtask : t_powerup_stalled

    task automatic t_shutdown_release();
        int c, t;
        @(posedge sys_clk) begin
            stall <= 1'b0;
            below_as <= 1'b0;
            below_sd <= 1'b1;
            above_rel <= 1'b0;
        end
        repeat (4) @(negedge sys_clk);
        check_bit("fault in shutdown", 1'b1, fault_pin);
        @(posedge sys_clk) below_sd <= 1'b0;
        count_high(2 * PER, c);
        check_range("drive below release", 0, 0, c);
        check_bit("fault below release", 1'b1, fault_pin);
        @(posedge sys_clk) above_rel <= 1'b1;
        wait_drive(8, t);
        check_range("start on release", 1, 6, t);
        repeat (34 * PER) @(negedge sys_clk);
    endtask : t_shutdown_release

    task automatic t_duty();
        logic [7:0] lvl [3] = '{8'h40, 8'h00, 8'hc0};
        int c;
        for (int i = 0; i < 3; i++) begin
            @(posedge sys_clk) control_level <= lvl[i];
            repeat (2 * PER) @(negedge sys_clk);
            count_high(PER, c);
            check_range("duty count", (lvl[i] > 1) ? lvl[i] - 2 : 0, lvl[i] + 2, c);
        end
    endtask : t_duty

    task automatic t_overtemp();
        int c;
        @(posedge sys_clk) begin
            control_level <= 8'hff;
            above_ot <= 1'b1;
        end
        repeat (2 * PER) @(negedge sys_clk);
        check_bit("overtemp warning", 1'b0, fault_pin);
        count_high(PER, c);
        check_range("drive at full", PER - 2, PER, c);
        @(posedge sys_clk) control_level <= 8'hfe;
        repeat (2 * PER) @(negedge sys_clk);
        check_bit("warning release", 1'b1, fault_pin);
    endtask : t_overtemp

    task automatic t_autoshut();
        int c, t;
        @(posedge sys_clk) begin
            control_level <= 8'hff;
            below_as <= 1'b1;
            above_hyst <= 1'b0;
        end
        repeat (4) @(negedge sys_clk);
        check_bit("drive in auto-off", 1'b0, fan_drive);
        repeat (2 * PER) @(negedge sys_clk);
        check_bit("fault in auto-off", 1'b1, fault_pin);
        @(posedge sys_clk) below_as <= 1'b0;
        count_high(2 * PER, c);
        check_range("drive inside hysteresis", 0, 0, c);
        @(posedge sys_clk) below_sd <= 1'b1;
        @(posedge sys_clk) below_sd <= 1'b0;
        count_high(2 * PER, c);
        check_range("drive after release below hysteresis", 0, 0, c);
        check_bit("fault after release below hysteresis", 1'b1, fault_pin);
        @(posedge sys_clk) begin
            control_level <= 8'h40;
            above_ot <= 1'b0;
            above_hyst <= 1'b1;
        end
        wait_drive(8, t);
        check_range("restart from auto-off", 1, 6, t);
        count_high(PER, c);
        check_range("start-up held on", PER, PER, c);
        repeat (6 * PER) @(negedge sys_clk);
    endtask : t_autoshut

    task automatic t_run_fault();
        int t, run, best;
        t = 0;
        run = 0;
        best = 0;
        @(posedge sys_clk) stall <= 1'b1;
        while (fault_pin !== 1'b0 && t < 80 * PER) begin
            @(negedge sys_clk);
            t++;
            run = (fan_drive === 1'b1) ? run + 1 : 0;
            if (run > best) best = run;
        end
        check_range("time to fan fault", 65 * PER, 71 * PER, t);
        check_range("diag and restart hold", 35 * PER - 2, 36 * PER, best);
        check_bit("drive after fan fault", 1'b0, fan_drive);
    endtask : t_run_fault

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        sys_clk = 1'b0;
        forever #2 sys_clk = ~sys_clk;
    end

    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (cyc == LIMIT) begin
            failures = failures + 1;
            summarize();
        end
    end

    initial begin
        rst_b = 1'b0;
        stall = 1'b1;
        control_level = 8'h40;
        below_sd = 1'b0;
        above_rel = 1'b1;
        below_as = 1'b0;
        above_hyst = 1'b1;
        above_ot = 1'b0;
        repeat (6) @(posedge sys_clk);
        check_bit("drive in reset", 1'b0, fan_drive);
        check_bit("fault in reset", 1'b1, fault_pin);
        rst_b <= 1'b1;
        t_powerup_stalled();
        t_shutdown_release();
        t_duty();
        t_overtemp();
        t_autoshut();
        t_run_fault();
        summarize();
    end
endmodule : tb_top
